/* include/fcs_pkg.sv */
package fcs_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned IDX_CONTROL     = 0;
  localparam int unsigned IDX_SOURCE_MODE = 1;
  localparam int unsigned IDX_STATE       = 2;
  localparam int unsigned ADDR_W          = 8;

  // Control fields
  localparam int unsigned CTL_ENABLE_BIT  = 0;
  localparam int unsigned CTL_FIE_BIT     = 1;
  localparam int unsigned CTL_SOFTRST_BIT = 7;
  // Source and mode fields
  localparam int unsigned SM_SEL_LSB      = 0;
  localparam int unsigned SM_MODE_LSB     = 4;
  // State fields
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_PASS_BIT     = 1;

  // Reset values
  localparam logic       ENABLE_RST = 1'b0;
  localparam logic       FIE_RST    = 1'b0;
  localparam logic [1:0] SEL_RST    = 2'h0;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic       BUSY_RST   = 1'b0;
  localparam logic       PASS_RST   = 1'b1;

  // Section select encodings
  localparam logic [1:0] SEL_FULL     = 2'h0;
  localparam logic [1:0] SEL_BOOT_APP = 2'h1;
  localparam logic [1:0] SEL_BOOT     = 2'h2;
  // Access modes
  localparam logic [1:0] MODE_PRIORITY = 2'h0;
  localparam logic [1:0] MODE_INIT     = 2'h1;

  // Timing in clock cycles
  localparam logic [1:0] START_DELAY  = 2'h3;
  localparam logic [1:0] FETCH_PERIOD = 2'h3;

  // CRC-16-CCITT
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DELAY  = 2'b01,
    ST_SCAN   = 2'b10,
    ST_FINISH = 2'b11
  } fcs_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } fcs_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fcs_apb_rsp_s;

  typedef struct packed {
    logic       active;
    logic       internal_access;
    logic       disconnect;
    logic       status_read;
    logic       status_wr;
    logic [1:0] status_wdata;
  } fcs_dbg_s;

  typedef struct packed {
    logic        rd;
    logic [14:0] word_addr;
  } fcs_flash_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } fcs_flash_rsp_s;

  typedef struct packed {
    logic        reset_scan_en;
    logic [1:0]  reset_scan_select_fuse;
    logic [7:0]  boot_end_fuse;
    logic [7:0]  app_end_fuse;
    logic [15:0] last_flash_address;
  } fcs_fuse_s;
endpackage

/* hw/fcs_flash_checker.sv */
// Function
// [R01] Suspend on any debugger device access
// [R02] Restart suspended check on debugger release
// [R03] Busy stays 1, no checking while suspended
// [R04] Status mirror readable without suspending scanner
// [R05] Debugger busy write 0 aborts check
// [R06] Debugger busy write 1 schedules one check
// [R07] Busy blocks source/mode and enable writes; code blocks FIE set and new starts, but still writes the enable bit
// [R08] Debugger pass write 0 raises interrupt
// [R09] After interrupt all register writes rejected
// [R10] Debugger pass write 1 sets pass
// [R11] Debugger control writes same as CPU
// [R12] Scan starts three cycles after enable
// [R13] Failed reset-time scan holds device reset
// [R14] Reset scan leaves enable, mode, source
// [R15] Stall CPU while section is scanned
// [R16] Fetch one word every third cycle
// [R17] Checksum sits in last two section bytes
// [R18] Mismatch clears pass flag
// [R19] Pass clear with enable raises interrupt
// [R20] Enable set-only; interrupt sticky until reset
// [R21] Halt in sleep, resume on wake
// [R22] Soft reset clears registers one clock later
// [R23] CRC-16-CCITT, low byte first, MSB first
// [R24] Section select encodes full, boot+app, boot
// [R25] Pass 1 at reset, 0 while busy
// [R26] Match at section end sets pass, clears busy
//
// Implementation choice: the APB slave port.
module fcs_flash_checker
  import fcs_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire fcs_apb_req_s   apb_req,
  output fcs_apb_rsp_s        apb_rsp,
  input  wire fcs_dbg_s       dbg,
  output logic [1:0]          dbg_status_mirror,
  output fcs_flash_req_s      flash_req,
  input  wire fcs_flash_rsp_s flash_rsp,
  input  wire fcs_fuse_s      fuse,
  input  wire logic           cpu_sleep,
  output logic                cpu_stall,
  output logic                hold_reset,
  output logic                nmi
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input int unsigned idx);
    return a == ADDR_W'(idx * 4);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  fcs_state_e  state_q;
  logic        enable_q;
  logic        fie_q;
  logic [1:0]  sel_q;
  logic [1:0]  mode_q;
  logic        busy_q;
  logic        pass_q;
  logic        nmi_q;
  logic        softrst_q;
  logic        suspend_q;
  logic        init_pend_q;
  logic        init_run_q;
  logic        init_fail_q;
  logic [1:0]  delay_q;
  logic [1:0]  phase_q;
  logic        wait_q;
  logic [14:0] word_q;
  logic [15:0] crc_q;
  logic [31:0] prdata_q;
  logic [1:0]  mirror_q;

  logic        apb_setup;
  logic        apb_wr;
  logic        hit_ctl;
  logic        hit_sm;
  logic        hit_st;
  logic        wr_ctl;
  logic        wr_sm;
  logic        dbg_wr;
  logic        dbg_busy0;
  logic        dbg_busy1;
  logic        dbg_pass0;
  logic        dbg_pass1;
  logic        softrst_ok;
  logic        start_sw;
  logic        start_init;
  logic        release_ev;
  logic        done;
  logic        match;
  logic        fail_ev;
  logic [15:0] end_byte;
  logic [14:0] last_word;
  logic [15:0] crc_next;
  logic [7:0]  rd_mux;

  // Bus decode
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign hit_ctl   = reg_hit(apb_req.paddr, IDX_CONTROL);
  assign hit_sm    = reg_hit(apb_req.paddr, IDX_SOURCE_MODE);
  assign hit_st    = reg_hit(apb_req.paddr, IDX_STATE);

  // CPU and debugger share this write path
  assign wr_ctl = apb_wr & hit_ctl & ~nmi_q; // see [R09] see [R11]
  assign wr_sm  = apb_wr & hit_sm & ~nmi_q & ~busy_q; // see [R07] see [R09]

  // Debugger writes to the state register
  assign dbg_wr    = dbg.status_wr & ~nmi_q; // see [R09]
  assign dbg_busy0 = dbg_wr & ~dbg.status_wdata[ST_BUSY_BIT];
  assign dbg_busy1 = dbg_wr & dbg.status_wdata[ST_BUSY_BIT];
  assign dbg_pass0 = dbg_wr & ~dbg.status_wdata[ST_PASS_BIT];
  assign dbg_pass1 = dbg_wr & dbg.status_wdata[ST_PASS_BIT];

  assign softrst_ok = wr_ctl & apb_req.pwdata[CTL_SOFTRST_BIT]
                      & (~busy_q | ~fie_q); // see [R22]
  assign start_sw   = wr_ctl & apb_req.pwdata[CTL_ENABLE_BIT] & ~busy_q
                      & ~softrst_ok;
  assign start_init = init_pend_q & fuse.reset_scan_en;
  assign release_ev = ~dbg.active & (dbg.internal_access | dbg.disconnect
                      | dbg.status_read); // see [R02] see [R04]

  assign done     = (state_q == ST_FINISH) & busy_q & ~suspend_q;
  assign match    = crc_q == CRC_RESIDUE; // see [R26]
  assign fail_ev  = (done & ~match) | dbg_pass0; // see [R08] see [R18]
  assign crc_next = crc_byte(crc_byte(crc_q, flash_rsp.rdata[7:0]),
                             flash_rsp.rdata[15:8]); // see [R23]

  // Section end: checksum high byte at end-1, low byte at end
  always_comb begin
    case (sel_q) // see [R24] see [R17]
      SEL_BOOT:     end_byte = 16'({fuse.boot_end_fuse, 8'h00} - 16'h0001);
      SEL_BOOT_APP: end_byte = 16'({fuse.app_end_fuse, 8'h00} - 16'h0001);
      SEL_FULL:     end_byte = fuse.last_flash_address;
      default:      end_byte = fuse.last_flash_address;
    endcase
  end
  assign last_word = end_byte[15:1];

  // Control and source/mode registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= ENABLE_RST;
      sel_q    <= SEL_RST;
      mode_q   <= MODE_RST;
    end else if (softrst_q) begin
      enable_q <= ENABLE_RST; // see [R22]
      sel_q    <= SEL_RST;
      mode_q   <= MODE_RST;
    end else if (start_init) begin
      enable_q <= 1'b1; // see [R14]
      sel_q    <= fuse.reset_scan_select_fuse;
      mode_q   <= MODE_INIT;
    end else begin
      if (wr_ctl) begin
        enable_q <= apb_req.pwdata[CTL_ENABLE_BIT];
      end
      if (wr_sm) begin
        sel_q  <= apb_req.pwdata[SM_SEL_LSB +: 2];
        mode_q <= apb_req.pwdata[SM_MODE_LSB +: 2];
      end
    end
  end

  // Interrupt enable: set only when idle, cleared only by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fie_q <= FIE_RST;
    end else if (wr_ctl & ~busy_q & apb_req.pwdata[CTL_FIE_BIT]) begin
      fie_q <= 1'b1; // see [R07] see [R20]
    end
  end

  // Soft reset strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      softrst_q <= 1'b0;
    end else begin
      softrst_q <= softrst_ok; // see [R22]
    end
  end

  // Busy flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= BUSY_RST;
    end else if (softrst_q) begin
      busy_q <= 1'b0;
    end else if (start_sw | start_init | dbg_busy1) begin
      busy_q <= 1'b1; // see [R06]
    end else if (dbg_busy0) begin
      busy_q <= 1'b0; // see [R05]
    end else if (done) begin
      busy_q <= 1'b0; // see [R26]
    end
  end

  // Pass flag; hardware result wins over debugger clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_q <= PASS_RST; // see [R25]
    end else if (softrst_q) begin
      pass_q <= 1'b0;
    end else if (start_sw | start_init | dbg_busy1) begin
      pass_q <= 1'b0; // see [R25]
    end else if (done) begin
      pass_q <= match; // see [R18] see [R26]
    end else if (dbg_pass0) begin
      pass_q <= 1'b0; // see [R08]
    end else if (dbg_pass1 & ~busy_q) begin
      pass_q <= 1'b1; // see [R10]
    end
  end

  // Non-maskable request, sticky until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_q <= 1'b0;
    end else if (fail_ev & fie_q) begin
      nmi_q <= 1'b1; // see [R19] see [R20]
    end
  end

  // Debugger suspend
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_q <= 1'b0;
    end else if (dbg.active) begin
      suspend_q <= 1'b1; // see [R01]
    end else if (release_ev) begin
      suspend_q <= 1'b0; // see [R02] see [R04]
    end
  end

  // Reset-time scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_pend_q <= 1'b1;
      init_run_q  <= 1'b0;
      init_fail_q <= 1'b0;
    end else begin
      init_pend_q <= 1'b0;
      if (start_init) begin
        init_run_q <= 1'b1;
      end else if (done | softrst_q) begin
        init_run_q <= 1'b0;
      end
      if (done & ~match & init_run_q) begin
        init_fail_q <= 1'b1; // see [R13]
      end
    end
  end

  // Scan engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      delay_q <= 2'h0;
      phase_q <= 2'h0;
      wait_q  <= 1'b0;
      word_q  <= 15'h0000;
      crc_q   <= CRC_INIT;
    end else if (softrst_q | ~busy_q) begin
      state_q <= ST_IDLE; // see [R05]
      wait_q  <= 1'b0;
    end else if (suspend_q) begin
      if (release_ev) begin
        state_q <= ST_IDLE; // see [R02]
        wait_q  <= 1'b0;
      end
    end else if (!cpu_sleep) begin // see [R03] see [R21]
      case (state_q)
        ST_IDLE: begin
          word_q  <= 15'h0000;
          crc_q   <= CRC_INIT;
          phase_q <= 2'h0;
          wait_q  <= 1'b0;
          delay_q <= START_DELAY - 2'h1;
          state_q <= init_run_q ? ST_SCAN : ST_DELAY;
        end
        ST_DELAY: begin
          if (delay_q == 2'h0) begin
            state_q <= ST_SCAN; // see [R12]
          end else begin
            delay_q <= delay_q - 2'h1;
          end
        end
        ST_SCAN: begin
          phase_q <= (phase_q == FETCH_PERIOD - 2'h1) ? 2'h0
                     : phase_q + 2'h1; // see [R16]
          if (phase_q == FETCH_PERIOD - 2'h1 && !wait_q) begin
            wait_q <= 1'b1;
          end
          if (wait_q && flash_rsp.valid) begin
            wait_q <= 1'b0;
            crc_q  <= crc_next;
            if (word_q == last_word) begin
              state_q <= ST_FINISH;
            end else begin
              word_q <= word_q + 15'h0001;
            end
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end else begin
      wait_q <= 1'b0; // see [R21]
    end
  end

  // Bus read data, captured in setup phase
  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctl) begin
      rd_mux[CTL_ENABLE_BIT] = enable_q;
      rd_mux[CTL_FIE_BIT]    = fie_q;
    end else if (hit_sm) begin
      rd_mux[SM_SEL_LSB +: 2]  = sel_q;
      rd_mux[SM_MODE_LSB +: 2] = mode_q;
    end else if (hit_st) begin
      rd_mux[ST_BUSY_BIT] = busy_q;
      rd_mux[ST_PASS_BIT] = pass_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Debugger status mirror
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mirror_q <= {PASS_RST, BUSY_RST};
    end else begin
      mirror_q <= {pass_q, busy_q}; // see [R04]
    end
  end

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable
                           & ~(hit_ctl | hit_sm | hit_st);

  assign flash_req.rd = (state_q == ST_SCAN) & busy_q & ~suspend_q
                        & ~cpu_sleep & ~wait_q
                        & (phase_q == FETCH_PERIOD - 2'h1); // see [R16]
  assign flash_req.word_addr = word_q;

  assign cpu_stall = busy_q & ((state_q == ST_SCAN)
                     | (state_q == ST_FINISH)); // see [R15]
  assign hold_reset = init_run_q | init_fail_q; // see [R13]
  assign nmi = nmi_q;
  assign dbg_status_mirror = mirror_q;

endmodule

/* tb/fcs_flash_model.sv */
module fcs_flash_model
  import fcs_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           slow,
  input  wire fcs_flash_req_s flash_req,
  output fcs_flash_rsp_s      flash_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [384];
  logic [14:0] addr_q;
  logic        pend_q;
  // Word one or two cycles after a fetch, junk data between words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q    <= 1'b0;
      addr_q    <= 15'h0;
      flash_rsp <= '0;
    end else begin
      flash_rsp.valid <= 1'b0;
      flash_rsp.rdata <= ~flash_rsp.rdata;
      pend_q          <= 1'b0;
      if (flash_req.rd && !slow) begin
        flash_rsp <= '{1'b1, mem[flash_req.word_addr]};
      end else if (flash_req.rd) begin
        pend_q <= 1'b1;
        addr_q <= flash_req.word_addr;
      end else if (pend_q) begin
        flash_rsp <= '{1'b1, mem[addr_q]};
      end
    end
  end
endmodule

/* tb/fcs_flash_checker_chk.sv */
module fcs_flash_checker_chk
  import fcs_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire fcs_apb_req_s   apb_req,
  input wire fcs_dbg_s       dbg,
  input wire logic [1:0]     dbg_status_mirror,
  input wire fcs_flash_req_s flash_req,
  input wire logic           cpu_sleep,
  input wire logic           cpu_stall,
  input wire logic           hold_reset,
  input wire logic           nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctl_on;
  assign ctl_on = apb_req.psel && apb_req.penable && apb_req.pwrite
                  && apb_req.paddr == 8'h00 && apb_req.pwdata[0];
  sequence s_start;
    ctl_on && !apb_req.pwdata[7] && !nmi && !cpu_stall && !hold_reset
    && !dbg_status_mirror[0] && !dbg.active && !cpu_sleep;
  endsequence
  sequence s_held;
    dbg.active && !dbg.status_wr ##1 dbg.active && !dbg.status_wr
    ##1 dbg.active && dbg_status_mirror[0] && !dbg.status_wr;
  endsequence
  AST_START_DELAY: assert property (s_start |=> !cpu_stall [*3])
    else $error("stall inside start delay");
  AST_FETCH_GAP: assert property (
    flash_req.rd |=> !flash_req.rd [*2])
    else $error("fetches closer than three cycles");
  AST_SUSPEND: assert property (dbg.active |=> !flash_req.rd)
    else $error("fetch while debugger active");
  AST_BUSY_HELD: assert property (
    s_held |=> dbg_status_mirror[0])
    else $error("busy lost while suspended");
  AST_PASS_LOW: assert property (
    dbg_status_mirror[0] |-> !dbg_status_mirror[1])
    else $error("pass set while busy");
  AST_NMI_STICKY: assert property (nmi |=> nmi)
    else $error("interrupt request dropped");
  AST_NMI_CAUSE: assert property (
    $rose(nmi) |-> ##[0:2] !dbg_status_mirror[1])
    else $error("interrupt without pass cleared");
  AST_NMI_LOCK: assert property (
    ctl_on && nmi && !dbg_status_mirror[0] |=> !cpu_stall [*8])
    else $error("scan started after interrupt");
  AST_RESET_SCAN_OK: assert property ($fell(hold_reset)
    |-> ##1 dbg_status_mirror == 2'b10)
    else $error("reset released without a pass");
endmodule
bind fcs_flash_checker fcs_flash_checker_chk fcs_flash_checker_chk_inst (
  .clk, .rst_n, .apb_req, .dbg, .dbg_status_mirror, .flash_req, .cpu_sleep,
  .cpu_stall, .hold_reset, .nmi);

/* tb/testbench.sv */
module testbench
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk;
  logic           rst_n;
  logic           cpu_sleep;
  logic           slow;
  fcs_apb_req_s   req;
  fcs_apb_rsp_s   rsp;
  fcs_dbg_s       dbg;
  fcs_flash_req_s freq;
  fcs_flash_rsp_s frsp;
  fcs_fuse_s      fuse;
  logic [1:0]     mirror;
  logic           stall;
  logic           hold;
  logic           nmi;
  logic [31:0]    r;
  logic           e;
  int             miscompares;
  int             comparisons;
  int             cyc;
  int             seed;
  fcs_flash_checker fcs_flash_checker_inst (.clk(clk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .dbg(dbg), .dbg_status_mirror(mirror),
    .flash_req(freq), .flash_rsp(frsp), .fuse(fuse), .cpu_sleep(cpu_sleep),
    .cpu_stall(stall), .hold_reset(hold), .nmi(nmi));
  fcs_flash_model fcs_flash_model_inst (.clk(clk), .rst_n(rst_n),
    .slow(slow), .flash_req(freq), .flash_rsp(frsp));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic dbgp(input logic [6:0] v);
    @(posedge clk);
    dbg <= fcs_dbg_s'(v);
    @(posedge clk);
    dbg <= fcs_dbg_s'({v[6], 6'h0});
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h08, 8'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 800);
  endtask
  task automatic scan(input logic [1:0] s, input logic [31:0] exp);
    slow <= 1'($random(seed));
    apb(1'b1, 8'h04, {6'h0, s});
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b0, 8'h08, 8'h0);
    chk(r, 32'h1);
    idle();
    chk(r, exp);
    $display("scan of section %0d done", s);
  endtask
  function automatic logic [15:0] crc(int nw);
    logic [15:0] c;
    logic [15:0] w;
    c = CRC_INIT;
    for (int i = 0; i < nw; i++) begin
      w = fcs_flash_model_inst.mem[i];
      for (int b = 0; b < 16; b++)
        c = {c[14:0], 1'b0}
            ^ ((c[15] ^ w[b < 8 ? 7 - b : 23 - b]) ? CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  initial begin
    seed = 32'hec67f436;
    clk = 1'b0;
    rst_n = 1'b0;
    cpu_sleep = 1'b0;
    slow = 1'b0;
    req = '0;
    dbg = '0;
    fuse = '{1'b0, SEL_BOOT, 8'h01, 8'h02, 16'h02ff};
    for (int i = 0; i < 384; i++)
      fcs_flash_model_inst.mem[i] = 16'($random(seed));
    for (int k = 1; k < 4; k++) begin
      r[15:0] = crc(k * 128 - 1);
      fcs_flash_model_inst.mem[k * 128 - 1] = {r[7:0], r[15:8]};
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 8'h0);
      chk(r, a == 8 ? 32'h2 : 32'h0);
    end
    chkb(e, 1'b1);
    $display("register reset values done");
    for (int s = 0; s < 3; s++)
      scan(2'(s), 32'h2);
    fcs_flash_model_inst.mem[5] ^= 16'h1;
    scan(SEL_BOOT, 32'h0);
    dbgp(7'b0000110);
    apb(1'b0, 8'h08, 8'h0);
    chk(r, 32'h2);
    fcs_flash_model_inst.mem[5] ^= 16'h1;
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h00, 8'h03);
    apb(1'b0, 8'h04, 8'h0);
    chk(r, 32'h2);
    apb(1'b0, 8'h00, 8'h0);
    chk(r, 32'h1);
    idle();
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h00, 8'h80);
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, 8'(a), 8'h0);
      chk(r, 32'h0);
    end
    $display("register protection done");
    apb(1'b1, 8'h04, 8'h02);
    apb(1'b1, 8'h00, 8'h01);
    repeat (30) @(posedge clk);
    dbg.active <= 1'b1;
    repeat (40) @(posedge clk);
    chk({30'h0, mirror}, 32'h1);
    dbgp(7'b0100000);
    idle();
    chk(r, 32'h2);
    apb(1'b1, 8'h00, 8'h01);
    dbg.active <= 1'b1;
    repeat (10) @(posedge clk);
    dbgp(7'b1000100);
    dbgp(7'b0010000);
    repeat (20) @(posedge clk);
    chkb(stall, 1'b0);
    apb(1'b0, 8'h08, 8'h0);
    chkb(r[0], 1'b0);
    dbg.active <= 1'b1;
    dbgp(7'b1000101);
    repeat (10) @(posedge clk);
    chk({30'h0, mirror}, 32'h1);
    dbgp(7'b0001000);
    idle();
    chk(r, 32'h2);
    $display("debugger control done");
    apb(1'b1, 8'h00, 8'h01);
    cpu_sleep <= 1'b1;
    repeat (20) @(posedge clk);
    chkb(stall, 1'b0);
    cpu_sleep <= 1'b0;
    repeat (60) @(posedge clk);
    chkb(stall, 1'b1);
    cpu_sleep <= 1'b1;
    repeat (30) @(posedge clk);
    cpu_sleep <= 1'b0;
    idle();
    chk(r, 32'h2);
    fcs_flash_model_inst.mem[5] ^= 16'h1;
    apb(1'b1, 8'h00, 8'h02);
    apb(1'b1, 8'h00, 8'h03);
    idle();
    chk(r, 32'h0);
    chkb(nmi, 1'b1);
    apb(1'b1, 8'h00, 8'h81);
    apb(1'b0, 8'h00, 8'h0);
    chk(r, 32'h3);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b0, 8'h04, 8'h0);
    chk(r, 32'h2);
    chkb(nmi, 1'b1);
    $display("failure interrupt done");
    rst_n <= 1'b0;
    fcs_flash_model_inst.mem[5] ^= 16'h1;
    fuse.reset_scan_en <= 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 1000 && hold !== 1'b0; n++)
      @(posedge clk);
    apb(1'b0, 8'h00, 8'h0);
    chk(r, 32'h1);
    apb(1'b0, 8'h04, 8'h0);
    chk(r, 32'h12);
    apb(1'b1, 8'h00, 8'h02);
    dbgp(7'b0000100);
    repeat (3) @(posedge clk);
    chkb(nmi, 1'b1);
    rst_n <= 1'b0;
    fcs_flash_model_inst.mem[5] ^= 16'h1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (1500) @(posedge clk);
    chkb(hold, 1'b1);
    $display("reset time scan done");
    stop_test();
  end
endmodule
